// *** src/hold_timer.sv ***
// per-input press-and-hold timer emitting repeat pulses
`timescale 1ns/100ps
module hold_timer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // timing
   input wire logic ms_tick,
   input wire logic [touch_qual_pkg::MS_W-1:0] press_ms,
   input wire logic [touch_qual_pkg::MS_W-1:0] repeat_ms,
   // input state
   input wire logic touched,
   input wire logic repeat_en,
   output logic repeat_pulse
);
   typedef enum logic [1:0] {IDLE = 2'b00, PRESS = 2'b01, HOLD = 2'b11} hold_e;
   hold_e state;
   logic [touch_qual_pkg::MS_W-1:0] elapsed;

   always_ff @(posedge ref_clk) begin
      if (rst || !touched) begin
         state <= IDLE;
         elapsed <= '0;
         repeat_pulse <= 1'b0;
      end else begin
         repeat_pulse <= 1'b0;
         unique case (state)
            IDLE: begin
               state <= PRESS;
               elapsed <= '0;
            end
            PRESS: begin
               if (ms_tick) begin
                  // strictly longer than the setting counts as a hold
                  if (elapsed > press_ms) begin
                     state <= HOLD;
                     elapsed <= '0;
                     repeat_pulse <= repeat_en;
                  end else begin
                     elapsed <= elapsed + 1'b1;
                  end
               end
            end
            HOLD: begin
               if (ms_tick) begin
                  if (elapsed + 1'b1 >= repeat_ms) begin
                     elapsed <= '0;
                     repeat_pulse <= repeat_en;
                  end else begin
                     elapsed <= elapsed + 1'b1;
                  end
               end
            end
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end
endmodule // hold_timer

// *** src/touch_event_qualifier.sv ***
// touch qualification, multi-touch blocking, pattern detection and interrupt
`timescale 1ns/100ps
module touch_event_qualifier #(
   parameter int MS_CYCLES = touch_qual_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // settings held elsewhere in the device
   input wire logic [3:0] min_press_code,
   input wire logic [3:0] repeat_rate_code,
   input wire logic [7:0] release_irq_enable,
   input wire logic [7:0] pattern_mask,
   input wire logic [6:0] touch_threshold,
   // host writes zero to the general interrupt bit
   input wire logic int_clear,
   // measurement results, one poll cycle per poll_tick
   input wire logic poll_tick,
   input wire logic [7:0] touch_raw,
   input wire logic [63:0] delta_counts,
   input wire logic [7:0] noise_flag,
   // status and interrupt
   output logic [7:0] touch_status,
   output logic [7:0] flagged,
   output logic over_limit_status,
   output logic pattern_event_status,
   output logic [6:0] pattern_threshold,
   output logic irq_n
);
   localparam int TW = $clog2(MS_CYCLES);

   logic [7:0] touch_irq_enable;
   logic [7:0] repeat_rate_enable;
   logic [7:0] multi_touch_config;
   logic [7:0] touch_pattern_config;
   logic [TW-1:0] ms_count;
   logic ms_tick;
   logic pattern_active;
   logic irq_pending;
   logic [7:0] prev_flagged;
   logic [7:0] repeat_pulse;
   logic [7:0] above;
   logic pattern_cond;
   logic [7:0] next_flagged;
   logic [2:0] limit;
   logic [7:0] touch_evt;
   logic [7:0] release_evt;
   logic [7:0] irq_evt;
   logic pattern_rise;
   logic any_event;
   // how long input 1 has stayed flagged, for the hold check
   logic [touch_qual_pkg::MS_W-1:0] held_ms;

   // fill the allowed slots in scan order, input 1 first
   function automatic logic [7:0] fill_slots(input logic [7:0] base, input logic [7:0] cand,
                                             input logic [2:0] lim);
      logic [7:0] r;
      logic [3:0] n;
      r = base;
      n = touch_qual_pkg::popcount8(base);
      for (int i = 0; i < 8; i++) begin
         if (cand[i] && !r[i] && n < {1'b0, lim}) begin
            r[i] = 1'b1;
            n = n + 4'h1;
         end
      end
      return r;
   endfunction

   // register writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         touch_irq_enable <= touch_qual_pkg::RST_IRQ_ENABLE;
         repeat_rate_enable <= touch_qual_pkg::RST_REPEAT_ENABLE;
         multi_touch_config <= touch_qual_pkg::RST_MULTI_TOUCH;
         touch_pattern_config <= touch_qual_pkg::RST_PATTERN_CFG;
      end else if (reg_wr) begin
         unique case (reg_addr)
            touch_qual_pkg::REG_IRQ_ENABLE: touch_irq_enable <= reg_wdata;
            touch_qual_pkg::REG_REPEAT_ENABLE: repeat_rate_enable <= reg_wdata;
            touch_qual_pkg::REG_MULTI_TOUCH:
               multi_touch_config <= reg_wdata & touch_qual_pkg::MULTI_TOUCH_MASK;
            touch_qual_pkg::REG_PATTERN_CFG:
               touch_pattern_config <= reg_wdata & touch_qual_pkg::PATTERN_CFG_MASK;
            default: ;
         endcase
      end
   end

   // register reads, unmapped addresses read zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         unique case (reg_addr)
            touch_qual_pkg::REG_IRQ_ENABLE: reg_rdata <= touch_irq_enable;
            touch_qual_pkg::REG_REPEAT_ENABLE: reg_rdata <= repeat_rate_enable;
            touch_qual_pkg::REG_MULTI_TOUCH: reg_rdata <= multi_touch_config;
            touch_qual_pkg::REG_PATTERN_CFG: reg_rdata <= touch_pattern_config;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // millisecond timebase for hold and repeat timing
   always_ff @(posedge ref_clk) begin
      if (rst || ms_count == TW'(MS_CYCLES - 1)) begin
         ms_count <= '0;
      end else begin
         ms_count <= ms_count + 1'b1;
      end
   end
   assign ms_tick = (ms_count == TW'(MS_CYCLES - 1));

   // pattern threshold scaling
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pattern_threshold <= 7'h00;
      end else begin
         unique case (touch_pattern_config[touch_qual_pkg::SCALE_LSB +: 2])
            touch_qual_pkg::SCALE_EIGHTH: pattern_threshold <= touch_threshold >> 3;
            touch_qual_pkg::SCALE_QUARTER: pattern_threshold <= touch_threshold >> 2;
            touch_qual_pkg::SCALE_3EIGHTHS:
               pattern_threshold <= (touch_threshold >> 2) + (touch_threshold >> 3);
            touch_qual_pkg::SCALE_FULL: pattern_threshold <= touch_threshold;
         endcase
      end
   end

   // inputs above the pattern threshold or flagged noisy
   for (genvar g = 0; g < 8; g++) begin : g_above
      assign above[g] = (delta_counts[g*8 +: 8] > {1'b0, pattern_threshold}) || noise_flag[g];
   end

   // an empty mask never matches
   always_comb begin
      pattern_cond = 1'b0;
      if (touch_pattern_config[touch_qual_pkg::DETECT_EN_BIT] && pattern_mask != 8'h00) begin
         if (touch_pattern_config[touch_qual_pkg::COMPARE_BIT]) begin
            pattern_cond = ((above & pattern_mask) == pattern_mask);
         end else begin
            pattern_cond = touch_qual_pkg::popcount8(above) >=
                           touch_qual_pkg::popcount8(pattern_mask);
         end
      end
   end

   // touch blocking
   assign limit = {1'b0, multi_touch_config[touch_qual_pkg::LIMIT_LSB +: 2]} + 3'h1;
   always_comb begin
      next_flagged = touch_raw;
      if (pattern_cond) begin
         next_flagged = 8'h00;
      end else if (multi_touch_config[touch_qual_pkg::BLOCK_EN_BIT]) begin
         // a released valid pad, or a limit lowered below the kept pads, reopens the selection
         if ((flagged & ~touch_raw) != 8'h00 ||
             touch_qual_pkg::popcount8(flagged) > {1'b0, limit}) begin
            next_flagged = fill_slots(8'h00, touch_raw, limit);
         end else begin
            next_flagged = fill_slots(flagged & touch_raw, touch_raw, limit);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flagged <= 8'h00;
         pattern_active <= 1'b0;
      end else if (poll_tick) begin
         flagged <= next_flagged;
         pattern_active <= pattern_cond;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prev_flagged <= 8'h00;
      end else begin
         prev_flagged <= flagged;
      end
   end

   for (genvar g = 0; g < 8; g++) begin : g_hold
      hold_timer u_hold (
         .ref_clk(ref_clk),
         .rst(rst),
         .ms_tick(ms_tick),
         .press_ms(touch_qual_pkg::step_ms(min_press_code)),
         .repeat_ms(touch_qual_pkg::step_ms(repeat_rate_code)),
         .touched(flagged[g]),
         .repeat_en(repeat_rate_enable[g]),
         .repeat_pulse(repeat_pulse[g])
      );
   end

   // events: first touch, enabled release and repeats
   assign touch_evt = flagged & ~prev_flagged;
   assign release_evt = prev_flagged & ~flagged & release_irq_enable;
   assign irq_evt = (touch_evt | release_evt | repeat_pulse) & touch_irq_enable;
   assign pattern_rise = poll_tick && pattern_cond && !pattern_active;
   assign any_event = (irq_evt != 8'h00) ||
                      (pattern_rise && touch_pattern_config[touch_qual_pkg::ALERT_BIT]);

   // sticky status, a set in the clear cycle wins
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         touch_status <= 8'h00;
         over_limit_status <= 1'b0;
         irq_pending <= 1'b0;
         irq_n <= 1'b1;
      end else begin
         touch_status <= (int_clear ? 8'h00 : touch_status) | touch_evt;
         if (poll_tick && multi_touch_config[touch_qual_pkg::BLOCK_EN_BIT] &&
             touch_qual_pkg::popcount8(touch_raw) > {1'b0, limit}) begin
            over_limit_status <= 1'b1;
         end else if (int_clear) begin
            over_limit_status <= 1'b0;
         end
         irq_pending <= any_event || (irq_pending && !int_clear);
         irq_n <= !(any_event || (irq_pending && !int_clear));
      end
   end

   // pattern status survives a clear while the condition holds
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pattern_event_status <= 1'b0;
      end else if (poll_tick && pattern_cond) begin
         pattern_event_status <= 1'b1;
      end else if (int_clear && !pattern_active && !pattern_cond) begin
         pattern_event_status <= 1'b0;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   reset_enables_a: assert property ($past(rst) |-> touch_irq_enable == 8'hFF &&
                                     multi_touch_config == 8'h80 && touch_pattern_config == 8'h00)
      else $error("enables not at reset value");
   masked_touch_a: assert property (irq_evt == 8'h00 && !pattern_rise && !irq_pending
                                    |=> irq_n)
      else $error("interrupt raised with no enabled event");
   irq_raise_a: assert property (any_event |=> !irq_n ##0 irq_pending)
      else $error("event did not raise interrupt");
   irq_hold_a: assert property (irq_pending && !int_clear |=> !irq_n && irq_pending)
      else $error("interrupt dropped without clear");
   unblocked_a: assert property (poll_tick && !pattern_cond &&
                                 !multi_touch_config[7] |=> flagged == $past(touch_raw))
      else $error("touch blocked with blocking off");
   limit_kept_a: assert property (poll_tick && multi_touch_config[7] |=>
                                  touch_qual_pkg::popcount8(flagged) <= $past(limit))
      else $error("flagged touches exceed limit");
   over_limit_a: assert property (poll_tick && multi_touch_config[7] &&
                                  touch_qual_pkg::popcount8(touch_raw) > {1'b0, limit}
                                  |=> over_limit_status)
      else $error("over limit status not set");
   pattern_block_a: assert property (poll_tick && pattern_cond |=>
                                     flagged == 8'h00 && pattern_event_status)
      else $error("pattern event did not block");
   pattern_sticky_a: assert property (pattern_event_status && pattern_active
                                      |=> pattern_event_status)
      else $error("pattern status cleared during condition");
   full_scale_a: assert property (touch_pattern_config[3:2] == 2'b11 |=>
                                  pattern_threshold == $past(touch_threshold))
      else $error("full scale threshold wrong");

   // ms ticks input 1 has stayed flagged, saturating so long holds never wrap
   always_ff @(posedge ref_clk) begin
      if (rst || !flagged[0]) begin
         held_ms <= '0;
      end else if (ms_tick && held_ms != '1) begin
         held_ms <= held_ms + 1'b1;
      end
   end

   // the helper may see one tick more than the timer, never fewer
   hold_time_a: assert property (repeat_pulse[0] |->
                                 held_ms > touch_qual_pkg::step_ms(min_press_code))
      else $error("repeat pulse before the hold time");
   repeat_off_a: assert property (
                                  (repeat_pulse & ~$past(repeat_rate_enable)) == 8'h00)
      else $error("repeat pulse on a disabled input");
   release_irq_a: assert property (
                                   (release_evt & touch_irq_enable) != 8'h00 |=> !irq_n)
      else $error("enabled release did not interrupt");
   touch_seen_a: assert property (touch_evt != 8'h00 |=>
                                  (touch_status & $past(touch_evt)) == $past(touch_evt))
      else $error("touch status not set");
   pattern_alert_a: assert property (pattern_rise &&
                                     touch_pattern_config[touch_qual_pkg::ALERT_BIT] |=> !irq_n)
      else $error("pattern alert did not interrupt");
   pattern_off_a: assert property (poll_tick &&
                                   !touch_pattern_config[touch_qual_pkg::DETECT_EN_BIT]
                                   |=> !pattern_active && !$rose(pattern_event_status))
      else $error("pattern detection ran while disabled");
endmodule // touch_event_qualifier

// *** src/touch_qual_pkg.sv ***
// constants, register map and helpers for the touch event qualifier
// Functional notes
// - each input has its own interrupt enable, all enabled after reset
// - a cleared enable bit n-1 stops touches on input n raising the interrupt
// - repeat disabled: interrupt only on first touch and enabled release
// - repeat enabled, short touch: interrupt on touch and enabled release
// - repeat enabled, held touch: interrupt on touch, then at the repeat rate
// - touch longer than minimum-press setting is press-and-hold; 35 ms steps
// - blocking enable cleared: every touch reported; it resets set
// - blocking: flag up to the limit, keep valid inputs, block others
// - after a release, refill the allowed touches scanning input 1 to 8
// - limit field bits 3..2: 00 one, 01 two, 10 three, 11 four touches
// - touches above the limit set the over-limit status and are blocked
// - pattern detection runs only while its enable bit 7 is set, reset clear
// - pattern threshold is 12.5, 25, 37.5 or 100 percent of touch threshold
// - count mode: inputs over threshold or noisy reach the pattern bit count
// - pattern mode: every selected input over threshold or noisy
// - a pattern event blocks all touches while its condition lasts
// - pattern status clears only by host clear once the condition has gone
// - pattern event always sets status, interrupt only if alert enabled
package touch_qual_pkg;
   localparam int NUM_INPUTS = 8;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h27;
   localparam logic [7:0] REG_REPEAT_ENABLE = 8'h28;
   localparam logic [7:0] REG_MULTI_TOUCH = 8'h2A;
   localparam logic [7:0] REG_PATTERN_CFG = 8'h2B;
   localparam logic [7:0] RST_IRQ_ENABLE = 8'hFF;
   localparam logic [7:0] RST_REPEAT_ENABLE = 8'hFF;
   localparam logic [7:0] RST_MULTI_TOUCH = 8'h80;
   localparam logic [7:0] RST_PATTERN_CFG = 8'h00;
   localparam logic [7:0] MULTI_TOUCH_MASK = 8'h8C;
   localparam logic [7:0] PATTERN_CFG_MASK = 8'h8F;
   localparam int BLOCK_EN_BIT = 7;
   localparam int LIMIT_LSB = 2;
   localparam int DETECT_EN_BIT = 7;
   localparam int SCALE_LSB = 2;
   localparam int COMPARE_BIT = 1;
   localparam int ALERT_BIT = 0;
   // hold and repeat settings run in these steps
   localparam int STEP_MS = 35;
   localparam int CLK_PERIOD_PS = 8000;
   localparam int PS_PER_MS = 1000000000;
   localparam int MS_CYCLES = PS_PER_MS / CLK_PERIOD_PS;
   localparam int MS_W = 10;

   typedef enum logic [1:0] {
      SCALE_EIGHTH = 2'b00,
      SCALE_QUARTER = 2'b01,
      SCALE_3EIGHTHS = 2'b10,
      SCALE_FULL = 2'b11
   } scale_e;

   function automatic logic [3:0] popcount8(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

   // setting code 0..15 to milliseconds, code 0 is one step
   function automatic logic [MS_W-1:0] step_ms(input logic [3:0] code);
      return MS_W'(({6'h00, code} + 10'h001) * 10'(STEP_MS));
   endfunction
endpackage

// *** tb/sensor_model.sv ***
// front end model: polling cycle timebase and measurement results
`timescale 1ns/100ps
module sensor_model #(
   parameter int POLL = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // values requested by the bench
   input wire logic [7:0] touch_in,
   input wire logic [63:0] delta_in,
   input wire logic [7:0] noise_in,
   // measurement results
   output logic poll_tick,
   output logic [7:0] touch_raw,
   output logic [63:0] delta_counts,
   output logic [7:0] noise_flag
);
   logic [7:0] cnt;
   // results settle one cycle before the tick so the sample never races them
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt <= 8'h00;
         poll_tick <= 1'b0;
         touch_raw <= 8'h00;
         delta_counts <= 64'h0;
         noise_flag <= 8'h00;
      end else begin
         cnt <= (cnt == 8'(POLL - 1)) ? 8'h00 : cnt + 8'h01;
         poll_tick <= (cnt == 8'h01);
         if (cnt == 8'h00) begin
            touch_raw <= touch_in;
            delta_counts <= delta_in;
            noise_flag <= noise_in;
         end
      end
   end
endmodule // sensor_model

// *** tb/tb.sv ***
// self-checking bench for the touch event qualifier
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, int_clear = 1'b0, poll_tick, irq_n;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rel_en = 8'h00, mask = 8'h03;
   logic [7:0] touch_in = 8'h00, noise_in = 8'h00, touch_raw, noise_flag, touch_status, flagged;
   logic [63:0] delta_in = 64'h0, delta_counts;
   logic [6:0] pattern_threshold;
   logic over_limit_status, pattern_event_status;
   int error_cnt = 0, n_tests = 0;
   always #4 ref_clk = ~ref_clk;
   sensor_model model (.ref_clk(ref_clk), .rst(rst), .touch_in(touch_in), .delta_in(delta_in),
      .noise_in(noise_in), .poll_tick(poll_tick), .touch_raw(touch_raw),
      .delta_counts(delta_counts), .noise_flag(noise_flag));
   // short millisecond keeps a 35 ms step at 140 cycles
   touch_event_qualifier #(.MS_CYCLES(4)) uut (.ref_clk(ref_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .min_press_code(4'h0), .repeat_rate_code(4'h0), .release_irq_enable(rel_en),
      .pattern_mask(mask), .touch_threshold(7'h40), .int_clear(int_clear),
      .poll_tick(poll_tick), .touch_raw(touch_raw), .delta_counts(delta_counts),
      .noise_flag(noise_flag), .touch_status(touch_status), .flagged(flagged),
      .over_limit_status(over_limit_status), .pattern_event_status(pattern_event_status),
      .pattern_threshold(pattern_threshold), .irq_n(irq_n));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      repeat (2) @(posedge ref_clk);
      #1 chk8(reg_rdata, exp);
   endtask
   task automatic clr;
      @(posedge ref_clk);
      int_clear <= 1'b1;
      @(posedge ref_clk);
      int_clear <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   // result of a tick shows on irq_n at most two edges later
   task automatic polls(input int n);
      repeat (n) @(posedge poll_tick);
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      #1 chk8(flagged, 8'h00);
      chk1(irq_n, 1'b1);
      rd(8'h27, 8'hFF);
      rd(8'h28, 8'hFF);
      rd(8'h2A, 8'h80);
      rd(8'h2B, 8'h00);
      rd(8'h29, 8'h00);
      wr(8'h2A, 8'hFF);
      rd(8'h2A, 8'h8C);
      wr(8'h2B, 8'hFF);
      rd(8'h2B, 8'h8F);
      wr(8'h2B, 8'h00);
      // enable gating on input 1
      touch_in <= 8'h01;
      polls(2);
      chk1(irq_n, 1'b0);
      touch_in <= 8'h00;
      wr(8'h27, 8'hFE);
      polls(2);
      clr();
      touch_in <= 8'h01;
      polls(2);
      chk1(irq_n, 1'b1);
      chk8(touch_status, 8'h01);
      touch_in <= 8'h00;
      wr(8'h27, 8'hFF);
      // each limit code flags the lowest inputs in scan order
      for (int k = 0; k < 4; k++) begin
         wr(8'h2A, 8'h80 | 8'(k << 2));
         polls(2);
         clr();
         chk1(over_limit_status, 1'b0);
         touch_in <= 8'hFF;
         polls(2);
         chk8(flagged, 8'((1 << (k + 1)) - 1));
         chk1(over_limit_status, 1'b1);
         touch_in <= 8'h00;
      end
      wr(8'h2A, 8'h80);
      polls(2);
      touch_in <= 8'h03;
      polls(2);
      chk8(flagged, 8'h01);
      touch_in <= 8'h02;
      polls(2);
      chk8(flagged, 8'h02);
      wr(8'h2A, 8'h00);
      touch_in <= 8'hFF;
      polls(2);
      chk8(flagged, 8'hFF);
      touch_in <= 8'h00;
      wr(8'h2A, 8'h80);
      // held touch with repeat off, then on
      wr(8'h28, 8'h00);
      polls(2);
      touch_in <= 8'h01;
      polls(2);
      clr();
      polls(20);
      chk1(irq_n, 1'b1);
      chk8(touch_status, 8'h00);
      touch_in <= 8'h00;
      wr(8'h28, 8'hFF);
      polls(2);
      touch_in <= 8'h01;
      polls(2);
      clr();
      polls(20);
      chk1(irq_n, 1'b0);
      touch_in <= 8'h00;
      polls(2);
      // short touch, release interrupt on and off
      for (int r = 0; r < 2; r++) begin
         @(posedge ref_clk);
         rel_en <= r ? 8'h00 : 8'hFF;
         touch_in <= 8'h01;
         polls(2);
         clr();
         touch_in <= 8'h00;
         polls(2);
         chk1(irq_n, 1'(r));
      end
      // threshold scale table with a threshold of 64
      for (int s = 0; s < 4; s++) begin
         wr(8'h2B, 8'h80 | 8'(s << 2));
         repeat (3) @(posedge ref_clk);
         #1 chk8({1'b0, pattern_threshold}, (s == 3) ? 8'h40 : 8'(8 * (s + 1)));
      end
      // count mode, no alert: inputs 5 and 6 meet a two bit mask
      wr(8'h2B, 8'h80);
      clr();
      delta_in <= 64'h0000_2020_0000_0000;
      touch_in <= 8'h01;
      polls(2);
      chk1(pattern_event_status, 1'b1);
      chk1(irq_n, 1'b1);
      chk8(flagged, 8'h00);
      clr();
      chk1(pattern_event_status, 1'b1);
      delta_in <= 64'h0;
      polls(2);
      chk8(flagged, 8'h01);
      clr();
      chk1(pattern_event_status, 1'b0);
      touch_in <= 8'h00;
      // pattern mode with alert; noise flag stands in for one input
      wr(8'h2B, 8'h83);
      delta_in <= 64'h0000_2020_0000_0000;
      polls(2);
      chk1(pattern_event_status, 1'b0);
      delta_in <= 64'h20;
      noise_in <= 8'h02;
      polls(2);
      chk1(pattern_event_status, 1'b1);
      chk1(irq_n, 1'b0);
      wr(8'h2B, 8'h03);
      delta_in <= 64'h0;
      noise_in <= 8'h00;
      polls(2);
      clr();
      delta_in <= 64'h20;
      noise_in <= 8'h02;
      polls(2);
      chk1(pattern_event_status, 1'b0);
      test_done();
   end
endmodule // tb
